// ### logic/acs_pkg.sv
// Purpose: Constants and types for the converter conversion sequencer
// Assumes: One 25 MHz system clock, synchronous active-high reset
// Notes: Counts and the external and floating source codes live here
package acs_pkg;
	// ----------------------------------------
	// Conversion timing in converter clocks
	// ----------------------------------------
	localparam logic [4:0] ACS_SAMPLE_CLKS = 5'h04;
	localparam logic [4:0] ACS_CONVERT_CLKS = 5'h0c;
	localparam logic [4:0] ACS_TOTAL_CLKS = ACS_SAMPLE_CLKS + ACS_CONVERT_CLKS;
	// ----------------------------------------
	// Result and divider
	// ----------------------------------------
	localparam int ACS_RES_BITS = 12;
	localparam logic [11:0] ACS_FULL_SCALE = 12'hfff;
	localparam logic [6:0] ACS_DIV_RESET = 7'h00;
	localparam logic [3:0] ACS_SRC_EXTERNAL = 4'h0;
	localparam logic [3:0] ACS_SRC_FLOAT = 4'h4;
	localparam logic [7:0] ACS_BYTE_RESET = 8'h00;
	localparam logic [3:0] ACS_CHAN_COUNT = 4'h8;

	typedef enum logic [1:0] {
		ACS_IDLE = 2'b00,
		ACS_SAMPLE = 2'b01,
		ACS_CONVERT = 2'b10
	} acs_state_type;
endpackage

// ### logic/acs_sequencer.sv
// Purpose: Sequencing of a 12-bit successive approximation converter
// Assumes: Analog core returns one comparator bit per converter clock
// Notes: Control bits arrive as plain ports, no register bus
//
// Functional notes
// [R1] 4 sample clocks then 12 convert clocks
// [R2] Low-high-low start pulse launches a conversion
// [R3] Busy high during conversion, low after
// [R4] Result bytes valid once busy falls
// [R5] Internal source codes route internal analog signal
// [R6] Internal source disconnects every external channel
// [R7] External source connects channel selected by field
// [R8] Result byte layout follows format select bit
// [R9] Reference select field chooses reference source
// [R10] Interrupt needs global and conversion enables
// [R11] Power enable clear switches converter off
// [R12] Result is 12-bit unsigned, fff full scale
// [R13] Code step equals reference over 4096
// [R14] Software sets up in documented order
// [R15] Software may poll busy instead of interrupt
// [R16] Software configures shared pin as analog
// [R17] Completion sets the interrupt request flag
// [R18] Converter clock divided by 3-bit select field
// [R19] Result held; no run while powered down
// [R20] Phase counter on converter clock clears busy
`timescale 1ns/100ps
module acs_sequencer
	import acs_pkg::*;
(
	input wire logic i_mclk, // System clock
	input wire logic i_reset, // Sync reset, active high
	input wire logic i_converter_power_enable, // Converter power on
	input wire logic i_start, // Start control bit
	input wire logic [2:0] i_converter_clock_divider_select, // Divide ratio 2^n
	input wire logic [3:0] i_input_source_select, // Input source field
	input wire logic [3:0] i_external_channel_select, // External channel field
	input wire logic i_result_format_select, // 0 left, 1 right aligned
	input wire logic [1:0] i_reference_select, // Reference source field
	input wire logic i_global_interrupt_enable, // Global interrupt enable
	input wire logic i_conversion_interrupt_enable, // Conversion interrupt enable
	input wire logic i_flag_clear, // Software clears request flag
	input wire logic i_comparator, // Comparator: input at or above trial
	output logic o_conversion_busy_flag, // Conversion in progress
	output logic [7:0] o_result_high_byte, // Result high byte
	output logic [7:0] o_result_low_byte, // Result low byte
	output logic o_conversion_interrupt_request_flag, // Sticky completion flag
	output logic o_interrupt, // Interrupt to core
	output logic o_analog_power, // Analog circuitry power
	output logic o_sample_enable, // Sampling switch closed
	output logic [11:0] o_trial_code, // DAC trial code, step vref/4096
	output logic [7:0] o_channel_connect, // One-hot external channel switch
	output logic [3:0] o_internal_select, // Internal signal mux code
	output logic [1:0] o_reference_route // Reference mux code
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	acs_state_type state_r, state_nxt;
	logic [6:0] div_r, div_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic [11:0] sar_r, sar_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic start_d_r, start_d_nxt, armed_r, armed_nxt;
	logic busy_r, busy_nxt, flag_r, flag_nxt, irq_r, irq_nxt;
	logic [7:0] hi_r, hi_nxt, lo_r, lo_nxt, conn_r, conn_nxt;
	logic [3:0] isel_r, isel_nxt;
	logic [1:0] ref_r, ref_nxt;
	logic pwr_r, pwr_nxt, smp_r, smp_nxt;
	logic tick, start_pulse, done;

	// Divider terminal count for a 2^n ratio
	function automatic logic [6:0] div_limit(input logic [2:0] sel);
		div_limit = 7'((8'h01 << sel) - 8'h01);
	endfunction

	// Source code routes an internal signal (not external, not floating, top bits not 11)
	function automatic logic is_internal(input logic [3:0] src);
		is_internal = (src != ACS_SRC_EXTERNAL) && (src != ACS_SRC_FLOAT) && (src[3:2] != 2'b11);
	endfunction

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		sar_nxt = sar_r;
		bit_nxt = bit_r;
		busy_nxt = busy_r;
		hi_nxt = hi_r;
		lo_nxt = lo_r;
		done = 1'b0;
		// Divider runs only while powered, restarts with each conversion
		tick = (div_r >= div_limit(i_converter_clock_divider_select)); // [R18]
		div_nxt = (tick || !i_converter_power_enable) ? ACS_DIV_RESET : 7'(div_r + 7'h01);
		start_d_nxt = i_start;
		// Rising edge arms, falling edge launches: low-high-low pulse
		start_pulse = armed_r && start_d_r && !i_start; // [R2]
		armed_nxt = (armed_r || (!start_d_r && i_start)) && !start_pulse;
		unique case (state_r)
			ACS_IDLE: begin
				if (start_pulse && i_converter_power_enable) begin // [R19]
					state_nxt = ACS_SAMPLE;
					cnt_nxt = 5'h00;
					busy_nxt = 1'b1; // [R3]
					div_nxt = ACS_DIV_RESET;
				end
			end
			ACS_SAMPLE: begin
				if (tick) begin
					cnt_nxt = 5'(cnt_r + 5'h01); // [R20]
					if (cnt_r == ACS_SAMPLE_CLKS - 5'h01) begin // [R1]
						state_nxt = ACS_CONVERT;
						sar_nxt = 12'h800;
						bit_nxt = 4'hb;
					end
				end
			end
			ACS_CONVERT: begin
				if (tick) begin
					cnt_nxt = 5'(cnt_r + 5'h01);
					// Binary search: keep bit if input at or above trial, try next
					sar_nxt[bit_r] = i_comparator; // [R13]
					if (bit_r != 4'h0) begin
						sar_nxt[bit_r - 4'h1] = 1'b1;
						bit_nxt = bit_r - 4'h1;
					end
					if (cnt_r == ACS_TOTAL_CLKS - 5'h01) begin // [R1] [R20]
						done = 1'b1;
						state_nxt = ACS_IDLE;
						busy_nxt = 1'b0; // [R3]
						// Result updated only here, so held between conversions
						if (i_result_format_select) begin // [R8] [R12] [R4]
							hi_nxt = {4'h0, sar_nxt[11:8]};
							lo_nxt = sar_nxt[7:0];
						end else begin
							hi_nxt = sar_nxt[11:4];
							lo_nxt = {sar_nxt[3:0], 4'h0};
						end
					end
				end
			end
			default: begin
				state_nxt = ACS_IDLE;
				busy_nxt = 1'b0;
			end
		endcase
		// Power loss aborts a running conversion, result kept
		if (!i_converter_power_enable) begin // [R11]
			state_nxt = ACS_IDLE;
			busy_nxt = 1'b0;
		end
		// Set wins over clear
		flag_nxt = done || (flag_r && !i_flag_clear); // [R17]
		irq_nxt = flag_nxt && i_global_interrupt_enable && i_conversion_interrupt_enable; // [R10]
		// Analog routing
		pwr_nxt = i_converter_power_enable; // [R11]
		smp_nxt = (state_nxt == ACS_SAMPLE);
		isel_nxt = is_internal(i_input_source_select) ? i_input_source_select : 4'h0; // [R5]
		conn_nxt = 8'h00; // [R6]
		if (i_input_source_select == ACS_SRC_EXTERNAL && i_external_channel_select < ACS_CHAN_COUNT)
			conn_nxt = 8'h01 << i_external_channel_select[2:0]; // [R7]
		ref_nxt = i_reference_select; // [R9]
	end

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			state_r <= ACS_IDLE;
			div_r <= ACS_DIV_RESET;
			cnt_r <= 5'h00;
			sar_r <= 12'h000;
			bit_r <= 4'h0;
			start_d_r <= 1'b0;
			armed_r <= 1'b0;
			busy_r <= 1'b0;
			flag_r <= 1'b0;
			irq_r <= 1'b0;
			hi_r <= ACS_BYTE_RESET;
			lo_r <= ACS_BYTE_RESET;
			conn_r <= 8'h00;
			isel_r <= 4'h0;
			ref_r <= 2'h0;
			pwr_r <= 1'b0;
			smp_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			div_r <= div_nxt;
			cnt_r <= cnt_nxt;
			sar_r <= sar_nxt;
			bit_r <= bit_nxt;
			start_d_r <= start_d_nxt;
			armed_r <= armed_nxt;
			busy_r <= busy_nxt;
			flag_r <= flag_nxt;
			irq_r <= irq_nxt;
			hi_r <= hi_nxt;
			lo_r <= lo_nxt;
			conn_r <= conn_nxt;
			isel_r <= isel_nxt;
			ref_r <= ref_nxt;
			pwr_r <= pwr_nxt;
			smp_r <= smp_nxt;
		end
	end

	// Outputs straight from flops
	assign o_conversion_busy_flag = busy_r;
	assign o_result_high_byte = hi_r;
	assign o_result_low_byte = lo_r;
	assign o_conversion_interrupt_request_flag = flag_r;
	assign o_interrupt = irq_r;
	assign o_analog_power = pwr_r;
	assign o_sample_enable = smp_r;
	assign o_trial_code = sar_r;
	assign o_channel_connect = conn_r;
	assign o_internal_select = isel_r;
	assign o_reference_route = ref_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_reset);

	busy_on_start_a: assert property ( // [R2]
		(state_r == ACS_IDLE && start_pulse && i_converter_power_enable) |=> busy_r)
		else $error("busy not raised after start");
	sample_len_a: assert property ( // [R1]
		(state_r == ACS_SAMPLE && tick && cnt_r == 5'h03 && i_converter_power_enable)
		|=> state_r == ACS_CONVERT)
		else $error("sampling length wrong");
	busy_state_a: assert property (busy_r == (state_r != ACS_IDLE)) // [R3]
		else $error("busy disagrees with state");
	done_flag_a: assert property ($fell(busy_r) && pwr_r |-> flag_r) // [R17]
		else $error("flag not set at completion");
	irq_gate_a: assert property (irq_r |-> $past(i_global_interrupt_enable) // [R10]
		&& $past(i_conversion_interrupt_enable))
		else $error("interrupt without enables");
	power_off_a: assert property (!i_converter_power_enable |=> !busy_r && !pwr_r) // [R11]
		else $error("running while powered down");
	internal_disc_a: assert property (is_internal($past(i_input_source_select)) // [R6]
		|-> conn_r == 8'h00)
		else $error("external channel connected with internal source");
	result_hold_a: assert property (!done |=> $stable(hi_r) && $stable(lo_r)) // [R19]
		else $error("result changed without completion");
	right_fmt_a: assert property (done && i_result_format_select |=> hi_r[7:4] == 4'h0) // [R8]
		else $error("right aligned high nibble not zero");

	conv_done_c: cover property ($fell(busy_r) && flag_r);
	irq_c: cover property ($rose(irq_r));
	abort_c: cover property (busy_r ##1 !busy_r && !pwr_r);
endmodule

// ### sim/acs_analog_model.sv
// Purpose: Analog side model, comparator against a held input code
// Assumes: Level is the ideal code of the sampled input
// Notes: Unpowered comparator toggles so no read is a lucky constant
`timescale 1ns/100ps
module acs_analog_model (
	input wire logic i_mclk, // System clock
	input wire logic i_power, // Analog power
	input wire logic [11:0] i_trial, // Trial code
	input wire logic [11:0] i_level, // Input level code
	output logic o_comparator // Input at or above trial
);
	logic tog_r = 1'b0;
	// Free toggle for the powered-down case
	always @(posedge i_mclk) tog_r <= ~tog_r;
	// Whole-code compare, one step is vref over 4096
	assign o_comparator = i_power ? (i_level >= i_trial) : tog_r;
endmodule

// ### sim/acs_sequencer_bench.sv
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: Control bits driven 1 ns after the rising edge
// Notes: Expected bytes derived from the input level code
`timescale 1ns/100ps
module acs_sequencer_bench;
	import acs_pkg::*;
	logic i_mclk = 0, i_reset = 1, pwr = 0, start = 0, fmt = 0;
	logic gie = 0, cie = 0, fclr = 0, cmp, busy, flag, irq, apwr, samp;
	logic [2:0] div = 0;
	logic [3:0] src = 0, ch = 0, isel;
	logic [1:0] vsel = 0, rref;
	logic [11:0] level = 0, trial;
	logic [7:0] hi, lo, conn;
	logic [3:0] codes [8] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'hb};
	int n_mismatch = 0, total_checks = 0, s, sc;
	always #20 i_mclk = ~i_mclk;
	acs_sequencer u_acs_sequencer (.i_mclk(i_mclk), .i_reset(i_reset),
		.i_converter_power_enable(pwr), .i_start(start),
		.i_converter_clock_divider_select(div), .i_input_source_select(src),
		.i_external_channel_select(ch), .i_result_format_select(fmt),
		.i_reference_select(vsel), .i_global_interrupt_enable(gie),
		.i_conversion_interrupt_enable(cie), .i_flag_clear(fclr), .i_comparator(cmp),
		.o_conversion_busy_flag(busy), .o_result_high_byte(hi), .o_result_low_byte(lo),
		.o_conversion_interrupt_request_flag(flag), .o_interrupt(irq),
		.o_analog_power(apwr), .o_sample_enable(samp), .o_trial_code(trial),
		.o_channel_connect(conn), .o_internal_select(isel), .o_reference_route(rref));
	acs_analog_model u_acs_analog_model (.i_mclk(i_mclk), .i_power(apwr),
		.i_trial(trial), .i_level(level), .o_comparator(cmp));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_span(input int got, input int lo_b, input int hi_b);
		total_checks++;
		if (got < lo_b || got > hi_b) begin
			n_mismatch++;
			$display("[FAIL] %0t span %0d outside %0d..%0d", $time, got, lo_b, hi_b);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	// Low-high-low start, then time busy and sampling; loops bounded
	task automatic conv(output int span, output int sspan);
		int k;
		start = 1;
		step(1);
		start = 0;
		k = 0;
		span = 0;
		sspan = 0;
		while (busy !== 1'b1 && k < 8) begin
			step(1);
			k++;
		end
		while (busy === 1'b1 && span < 5000) begin
			sspan += (samp === 1'b1);
			step(1);
			span++;
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Tests take about 110 cycles; allow over twenty times that
	initial begin
		#100000;
		n_mismatch++;
		$display("[FAIL] %0t watchdog expired", $time);
		tally_and_finish();
	end
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		step(3);
		i_reset = 0;
		chk({busy, flag, irq, apwr, samp, rref, isel}, 0);
		chk({hi, lo[7:4]}, 0);
		$display("test reset done");
		pwr = 1; // divider left at its reset choice
		ch = 3; // pin taken as configured for analog
		level = 12'ha5c;
		vsel = 2;
		gie = 1;
		cie = 1;
		step(2);
		chk(apwr, 1);
		chk(rref, 2);
		conv(s, sc);
		chk_span(s, 16, 17);
		chk_span(sc, 4, 5);
		chk(hi, 8'ha5);
		chk(lo, 8'hc0);
		chk(flag, 1);
		chk(conn, 8'h08);
		step(1);
		chk(irq, 1);
		$display("test left aligned done");
		// Clear held through the next run: completion must still win
		fclr = 1;
		step(1);
		chk(flag, 0);
		cie = 0; // end found by polling busy
		fmt = 1;
		div = 1;
		level = ACS_FULL_SCALE;
		conv(s, sc);
		chk_span(s, 32, 33);
		chk(hi, 8'h0f);
		chk(lo, 8'hff);
		chk(flag, 1);
		fclr = 0;
		step(1);
		chk({flag, irq}, 2'b10);
		$display("test right aligned done");
		// Power dropped mid-run: abort, no flag, old result kept
		fclr = 1;
		step(1);
		fclr = 0;
		start = 1;
		step(1);
		start = 0;
		step(6);
		chk(busy, 1);
		pwr = 0;
		step(1);
		chk({busy, apwr, flag}, 0);
		chk({hi[3:0], lo}, 12'hfff);
		$display("test abort done");
		foreach (codes[i]) begin
			src = codes[i];
			step(2);
			chk(conn, 0);
			chk(isel, codes[i]);
		end
		src = 4;
		step(2);
		chk({isel, conn}, 0);
		src = 0;
		ch = 9;
		step(2);
		chk(conn, 0);
		for (int v = 0; v < 4; v++) begin
			vsel = v[1:0];
			step(2);
			chk(rref, v[1:0]);
		end
		$display("test routing done");
		pwr = 0;
		level = 12'h123;
		step(2);
		chk(apwr, 0);
		conv(s, sc);
		chk_span(s, 0, 0);
		chk({hi, lo[3:0]}, 12'h0ff);
		$display("test power off done");
		tally_and_finish();
	end
endmodule
